// [hdl/cvc_core_voltage.sv]
// Purpose: Voltage selection, control register and ramp for the second
//          core converter and the first core converter's voltage codes.
// Assumes: Port front ends give one-cycle access strobes on sys_clk;
//          reset_n is the turn-off reset; boot inputs are static.
// Notes:   Voltages are reported in 0.1 mV units.
// Operation
// - Command bit 0 applies operating code, 1 applies scaling code.
// - Code zero turns the output off at 0.0 V.
// - Codes one to three all give 0.6 V at unity gain.
// - Codes 3 to 75 give code times 12.5 mV plus 0.5625 V, times gain.
// - Codes 75 and above saturate at 1.5 V at unity gain.
// - Commanded output after gain never exceeds 3.3 V.
// - Voltage registers are reached only through the selected port.
// - Only the turn-off reset clears these registers.
// - Gain field 00 and 01 mean one, 10 two, 11 three.
// - Current-limit bit 0 means 1.0 A, 1 means above 1.5 A.
// - With stepping on, output moves in 12.5 mV increments at unity gain.
// - Step-time 000 applies the new target at once.
// - Step codes 001, 010, 011 step at full, three quarter, three fifth rate.
// - Step codes 100 to 111 step at rate divided by 2, 3, 4, 5.
// - Supply state 00 and 10 off, 01 high power, 11 low power.
// - Default voltage codes come from the boot configuration.
// - Only four operating code bits come from boot memory.
`timescale 1ns/1ps
`include "cvc_map.svh"
module cvc_core_voltage
    import cvc_pkg::*;
(
    // Clock and turn-off reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Boot configuration
    input wire logic [3:0] boot_op_bits,
    input wire logic [6:0] boot_sr_code,
    // Port selection, high routes voltage registers to the scaling port
    input wire logic scaling_port_select,
    // General control port
    input wire cvc_acc_s ctl_acc,
    output cvc_ans_s ctl_ans,
    // Voltage scaling port
    input wire cvc_acc_s sr_acc,
    output cvc_ans_s sr_ans,
    // Sampling clock pin
    input wire logic sample_clk,
    // Converter drive
    output cvc_drive_s drive_q
);

    logic [7:0] op_q;
    logic [6:0] sr_q;
    cvc_ctrl_s ctrl_q;
    logic boot_pend_q;
    logic [6:0] cur_q;
    logic [6:0] cur_d;
    logic samp_m_q;
    logic samp_s_q;
    logic samp_p_q;
    logic step_en;

    // Numeric gain factor from the gain field.
    function automatic logic [1:0] gain_of(input logic [1:0] g);
        case (g)
            `CVC_GAIN_X2: gain_of = 2'h2;
            `CVC_GAIN_X3: gain_of = 2'h3;
            default: gain_of = 2'h1;
        endcase
    endfunction

    // Commanded voltage in 0.1 mV units for a code and gain field.
    function automatic logic [15:0] code_to_volt(input logic [6:0] code,
                                                 input logic [1:0] g);
        logic [17:0] base;
        logic [17:0] prod;
        base = 18'h00000;
        prod = 18'h00000;
        if (code == `CVC_CODE_OFF)
            base = 18'h00000;
        else if (code <= `CVC_CODE_MIN)
            base = `CVC_V_MIN;
        else if (code >= `CVC_CODE_MAX)
            base = `CVC_V_SAT;
        else
            base = 18'(18'(code) * `CVC_V_STEP + `CVC_V_OFFSET);
        prod = 18'(base * 18'(gain_of(g)));
        if (prod > `CVC_V_CLAMP)
            prod = `CVC_V_CLAMP;
        code_to_volt = prod[15:0];
    endfunction

    // Register read value for one port; refused reads return zero.
    function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                            input logic volt_ok,
                                            input logic ctrl_ok,
                                            input logic [7:0] op,
                                            input logic [6:0] sr,
                                            input cvc_ctrl_s ctl);
        read_reg = 8'h00;
        if (volt_ok && addr == `CVC_OFS_OP)
            read_reg = op;
        else if (volt_ok && addr == `CVC_OFS_SR)
            read_reg = {1'b0, sr};
        else if (ctrl_ok && addr == `CVC_OFS_CTRL)
            read_reg = ctl;
    endfunction

    // Port routing: the unselected port cannot reach the voltage registers.
    wire logic ctl_volt = !scaling_port_select;
    wire logic sr_volt = scaling_port_select;
    wire logic ctl_op_wr = ctl_acc.wr && ctl_volt &&
                           ctl_acc.addr == `CVC_OFS_OP;
    wire logic sr_op_wr = sr_acc.wr && sr_volt && sr_acc.addr == `CVC_OFS_OP;
    wire logic ctl_sr_wr = ctl_acc.wr && ctl_volt &&
                           ctl_acc.addr == `CVC_OFS_SR;
    wire logic sr_sr_wr = sr_acc.wr && sr_volt && sr_acc.addr == `CVC_OFS_SR;
    wire logic op_wr = ctl_op_wr || sr_op_wr;
    wire logic srr_wr = ctl_sr_wr || sr_sr_wr;
    wire logic [7:0] volt_wdata = sr_volt ? sr_acc.wdata : ctl_acc.wdata;
    wire logic ctrl_wr = ctl_acc.wr && ctl_acc.addr == `CVC_OFS_CTRL;
    wire logic [7:0] boot_op = {1'b0, boot_op_bits, `CVC_BOOT_PAD};

    // Applied target code and ramp direction.
    wire logic [6:0] target = op_q[`CVC_CMD_BIT] ? sr_q : op_q[6:0];
    wire logic bypass = ctrl_q.ramp_step_time == `CVC_RAMP_STEP_TIME_BYPASS;
    wire logic go_up = cur_q < target;

    // Voltage registers; boot codes load on the first edge after release.
    // Only the turn-off reset reaches these flops.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            op_q <= `CVC_OP_RST;
            sr_q <= `CVC_SR_RST;
            boot_pend_q <= 1'b1;
        end
        else
        begin
            boot_pend_q <= 1'b0;
            if (boot_pend_q)
            begin
                op_q <= boot_op;
                sr_q <= boot_sr_code;
            end
            else
            begin
                if (op_wr)
                    op_q <= volt_wdata;
                if (srr_wr)
                    sr_q <= volt_wdata[6:0];
            end
        end
    end

    // Control register, written from the general control port only.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= '{`CVC_GAIN_RST, `CVC_ILIM_RST, `CVC_RAMP_STEP_TIME_RST,
                        `CVC_ST_RST};
        end
        else if (ctrl_wr && !boot_pend_q)
        begin
            ctrl_q <= ctl_acc.wdata;
        end
    end

    // Access answers, one cycle after each strobe.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctl_ans <= '0;
            sr_ans <= '0;
        end
        else
        begin
            ctl_ans.ack <= ctl_acc.wr || ctl_acc.rd;
            ctl_ans.rdata <= ctl_acc.rd ? read_reg(ctl_acc.addr, ctl_volt,
                             1'b1, op_q, sr_q, ctrl_q) : 8'h00;
            sr_ans.ack <= sr_acc.wr || sr_acc.rd;
            sr_ans.rdata <= sr_acc.rd ? read_reg(sr_acc.addr, sr_volt,
                            1'b0, op_q, sr_q, ctrl_q) : 8'h00;
        end
    end

    // Sampling clock pin: two flops, then a third for the edge.
    // The first flop feeds nothing but the second.
    // Flops reset high, so a pin already high at release gives no false tick.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            samp_m_q <= 1'b1;
            samp_s_q <= 1'b1;
            samp_p_q <= 1'b1;
        end
        else
        begin
            samp_m_q <= sample_clk;
            samp_s_q <= samp_m_q;
            samp_p_q <= samp_s_q;
        end
    end

    wire logic samp_tick = samp_s_q && !samp_p_q;

    cvc_step_div u_div (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .tick(samp_tick),
        .ramp_step_time(ctrl_q.ramp_step_time),
        .step_en_q(step_en)
    );

    // Ramp: one code per enabled tick, or a jump when stepping is bypassed.
    always_comb
    begin
        cur_d = cur_q;
        if (bypass)
            cur_d = target;
        else if (step_en && cur_q != target)
            cur_d = go_up ? 7'(cur_q + 7'h01) : 7'(cur_q - 7'h01);
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            cur_q <= `CVC_CODE_OFF;
        else
            cur_q <= cur_d;
    end

    // Drive outputs, all registered from the current code and control.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            drive_q <= '0;
        end
        else
        begin
            drive_q.on <= ctrl_q.st == `CVC_ST_HIGH ||
                          ctrl_q.st == `CVC_ST_LOW;
            drive_q.low_power <= ctrl_q.st == `CVC_ST_LOW;
            drive_q.ilim_high <= ctrl_q.ilim;
            drive_q.gain_factor <= gain_of(ctrl_q.gain);
            drive_q.code <= cur_q;
            drive_q.vout <= code_to_volt(cur_q, ctrl_q.gain);
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    cmd_select_a: assert property (
        (bypass && $stable(target) && $stable(op_q)) [*2] |->
        cur_q == (op_q[7] ? sr_q : op_q[6:0]))
        else $error("applied code does not follow command bit");

    off_code_a: assert property (
        cur_q == `CVC_CODE_OFF |=> drive_q.vout == 16'h0000)
        else $error("code zero did not give zero volts");

    min_code_a: assert property (
        (cur_q >= 7'h01 && cur_q <= 7'h03 && ctrl_q.gain == 2'h1) |=>
        drive_q.vout == 16'h1770)
        else $error("low codes did not give 0.6 V");

    linear_code_a: assert property (
        (cur_q == 7'h33 && ctrl_q.gain == 2'h0) |=> drive_q.vout == 16'h2EE0)
        else $error("code 51 did not give 1.2 V");

    sat_code_a: assert property (
        (cur_q >= 7'h4B && ctrl_q.gain == 2'h0) |=> drive_q.vout == 16'h3A98)
        else $error("high codes did not saturate at 1.5 V");

    clamp_a: assert property (
        drive_q.vout <= 16'h80E8)
        else $error("commanded output above 3.3 V");

    port_guard_a: assert property (
        (!boot_pend_q && sr_acc.wr && !scaling_port_select &&
         !(ctl_acc.wr && ctl_acc.addr == sr_acc.addr)) |=> $stable(op_q)
        || $past(sr_acc.addr) != 8'h22)
        else $error("unselected port changed the operating register");

    gain_map_a: assert property (
        ctrl_q.gain == 2'h3 ##1 ctrl_q.gain == 2'h3 |->
        drive_q.gain_factor == 2'h3)
        else $error("gain field 11 did not give factor three");

    step_size_a: assert property (
        (!bypass && !$past(bypass) && cur_q != $past(cur_q)) |->
        (cur_q == 7'($past(cur_q) + 7'h01) ||
         cur_q == 7'($past(cur_q) - 7'h01)))
        else $error("ramp moved by more than one code");

    bypass_jump_a: assert property (
        bypass |=> cur_q == $past(target))
        else $error("bypassed ramp did not jump to target");

    supply_state_a: assert property (
        ctrl_q.st == 2'h2 |=> !drive_q.on)
        else $error("supply state 10 did not turn the converter off");

    boot_load_a: assert property (
        boot_pend_q |=> op_q == $past(boot_op) && sr_q == $past(boot_sr_code))
        else $error("boot codes not loaded after reset");

endmodule

// [hdl/cvc_map.svh]
// Purpose: Offsets, field positions, reset values and limits of the core
//          converter voltage control block.
// Assumes: Voltages are counted in units of 0.1 mV.
// Notes:   Definitions only.
`ifndef CVC_MAP_SVH
`define CVC_MAP_SVH

// Register offsets.
`define CVC_OFS_OP 8'h22
`define CVC_OFS_SR 8'h23
`define CVC_OFS_CTRL 8'h24

// Field positions.
`define CVC_CMD_BIT 7
`define CVC_BOOT_LSB 3

// Reset values.
`define CVC_OP_RST 8'h00
`define CVC_SR_RST 7'h00
`define CVC_GAIN_RST 2'h0
`define CVC_ILIM_RST 1'h0
`define CVC_RAMP_STEP_TIME_RST 3'h1
`define CVC_ST_RST 2'h0
`define CVC_BOOT_PAD 3'h0

// Voltage code limits.
`define CVC_CODE_OFF 7'h00
`define CVC_CODE_MIN 7'h03
`define CVC_CODE_MAX 7'h4B

// Voltages in 0.1 mV units.
`define CVC_V_STEP 18'h0007D
`define CVC_V_OFFSET 18'h015F9
`define CVC_V_MIN 18'h01770
`define CVC_V_SAT 18'h03A98
`define CVC_V_CLAMP 18'h080E8

// Gain, supply state and step-time encodings.
`define CVC_GAIN_X2 2'h2
`define CVC_GAIN_X3 2'h3
`define CVC_ST_HIGH 2'h1
`define CVC_ST_LOW 2'h3
`define CVC_RAMP_STEP_TIME_BYPASS 3'h0
`define CVC_RAMP_STEP_TIME_FULL 3'h1
`define CVC_RAMP_STEP_TIME_3OF4 3'h2
`define CVC_RAMP_STEP_TIME_3OF5 3'h3
`define CVC_RAMP_STEP_TIME_DIV2 3'h4
`define CVC_RAMP_STEP_TIME_DIV3 3'h5
`define CVC_RAMP_STEP_TIME_DIV4 3'h6
`define CVC_RAMP_STEP_TIME_DIV5 3'h7
`define CVC_KEEP_ONE 3'h1
`define CVC_KEEP_THREE 3'h3
`define CVC_PER_1 3'h1
`define CVC_PER_2 3'h2
`define CVC_PER_3 3'h3
`define CVC_PER_4 3'h4
`define CVC_PER_5 3'h5
`define CVC_ZERO3 3'h0

`endif

// [hdl/cvc_pkg.sv]
// Purpose: Types shared by the core converter voltage control files.
// Assumes: Nothing beyond the map header.
// Notes:   Structs only; numbers live in cvc_map.svh.
package cvc_pkg;

    // One register access from a port front end.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cvc_acc_s;

    // Answer to an access, one cycle after it.
    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
    } cvc_ans_s;

    // Fields of the converter control register.
    typedef struct packed {
        logic [1:0] gain;
        logic ilim;
        logic [2:0] ramp_step_time;
        logic [1:0] st;
    } cvc_ctrl_s;

    // Drive toward the analog converter.
    typedef struct packed {
        logic on;
        logic low_power;
        logic ilim_high;
        logic [1:0] gain_factor;
        logic [6:0] code;
        logic [15:0] vout;
    } cvc_drive_s;

endpackage

// [hdl/cvc_step_div.sv]
// Purpose: Turns sampling ticks into ramp step enables at the rate chosen
//          by the step-time field.
// Assumes: tick is a one-cycle pulse on each sampling clock rising edge.
// Notes:   Fractional rates keep three ticks out of four or five.
`timescale 1ns/1ps
`include "cvc_map.svh"
module cvc_step_div
    import cvc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Rate control
    input wire logic tick,
    input wire logic [2:0] ramp_step_time,
    // Step enable
    output logic step_en_q
);

    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic prev_kept_q;
    logic [2:0] prev_ts_q;

    // Period of the tick pattern for each step-time code.
    function automatic logic [2:0] period(input logic [2:0] ts);
        case (ts)
            `CVC_RAMP_STEP_TIME_3OF4: period = `CVC_PER_4;
            `CVC_RAMP_STEP_TIME_3OF5: period = `CVC_PER_5;
            `CVC_RAMP_STEP_TIME_DIV2: period = `CVC_PER_2;
            `CVC_RAMP_STEP_TIME_DIV3: period = `CVC_PER_3;
            `CVC_RAMP_STEP_TIME_DIV4: period = `CVC_PER_4;
            `CVC_RAMP_STEP_TIME_DIV5: period = `CVC_PER_5;
            default: period = `CVC_PER_1;
        endcase
    endfunction

    // Ticks kept within one period.
    wire logic frac = (ramp_step_time == `CVC_RAMP_STEP_TIME_3OF4) || (ramp_step_time == `CVC_RAMP_STEP_TIME_3OF5);
    wire logic [2:0] keep = frac ? `CVC_KEEP_THREE : `CVC_KEEP_ONE;
    // Wrap also when a new code shortens the period below the count.
    wire logic wrap = (cnt_q >= period(ramp_step_time) - `CVC_PER_1);
    // Full rate ignores a count left over from an earlier code.
    wire logic keep_slot = (cnt_q < keep) || (ramp_step_time == `CVC_RAMP_STEP_TIME_FULL);
    wire logic keep_now = tick && keep_slot && (ramp_step_time != `CVC_RAMP_STEP_TIME_BYPASS);

    always_comb
    begin
        cnt_d = cnt_q;
        if (tick)
        begin
            cnt_d = wrap ? `CVC_ZERO3 : 3'(cnt_q + `CVC_PER_1);
        end
    end

    // Enable follows its tick by one cycle.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= `CVC_ZERO3;
            step_en_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            step_en_q <= keep_now;
        end
    end

    full_rate_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (tick && ramp_step_time == `CVC_RAMP_STEP_TIME_FULL) |=> step_en_q)
        else $error("full rate tick did not give a step");

    // Checker helper: whether the last tick was kept, and under which code.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prev_kept_q <= 1'b0;
            prev_ts_q <= `CVC_RAMP_STEP_TIME_BYPASS;
        end
        else if (tick)
        begin
            prev_kept_q <= keep_now;
            prev_ts_q <= ramp_step_time;
        end
    end

    div_rate_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (tick && ramp_step_time == `CVC_RAMP_STEP_TIME_DIV2 && prev_ts_q == `CVC_RAMP_STEP_TIME_DIV2 &&
         prev_kept_q) |=> !step_en_q)
        else $error("half rate gave steps on two successive ticks");

endmodule

// [verification/cvc_host_model.sv]
// Purpose: Host side of the two register ports of the converter block.
// Assumes: Requests start 1 ns after a rising sys_clk edge.
// Notes:   The caller picks the port, so a refused access can be provoked.
`timescale 1ns/1ps
module cvc_host_model
    import cvc_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Port selection
    output logic scaling_port_select,
    // Register ports
    output cvc_acc_s ctl_acc,
    input wire cvc_ans_s ctl_ans,
    output cvc_acc_s sr_acc,
    input wire cvc_ans_s sr_ans
);
    // Idle ports from time zero so no strobe is ever unknown.
    initial
    begin
        scaling_port_select = 1'b0;
        ctl_acc = '0;
        sr_acc = '0;
    end

    // Moves the voltage registers between the two ports.
    task automatic set_sel(input logic s);
        @(posedge sys_clk);
        #1 scaling_port_select = s;
    endtask

    // Strobe stands for one edge; the answer stands in the next cycle.
    task automatic xfer(input logic on_sr, input logic wr,
                        input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic ack);
        cvc_acc_s a;
        a = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
        @(posedge sys_clk);
        #1;
        if (on_sr)
            sr_acc = a;
        else
            ctl_acc = a;
        @(posedge sys_clk);
        #1;
        ctl_acc = '0;
        sr_acc = '0;
        ack = on_sr ? sr_ans.ack : ctl_ans.ack;
        rdata = on_sr ? sr_ans.rdata : ctl_ans.rdata;
    endtask
endmodule

// [verification/cvc_core_voltage_tb.sv]
// Purpose: Self-checking bench of the core converter voltage control.
// Assumes: Boot bits are static; the sampling pin runs free at 8 MHz.
// Notes:   Ramp rates are judged by steps counted over 60 sampling edges.
`timescale 1ns/1ps
module cvc_core_voltage_tb;
    import cvc_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic sample_clk = 1'b0;
    logic scaling_port_select;
    cvc_acc_s ctl_acc;
    cvc_acc_s sr_acc;
    cvc_ans_s ctl_ans;
    cvc_ans_s sr_ans;
    cvc_drive_s drive_q;
    int mismatches = 0;
    int checks = 0;
    logic [7:0] rd_q;
    logic ack_q;
    logic ramp_on = 1'b0;
    logic [6:0] code_prev;
    logic [6:0] codes [9] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h33, 7'h3F,
                              7'h4B, 7'h64, 7'h7F};
    int rate_steps [7] = '{60, 45, 36, 30, 20, 15, 12};
    int start;
    int n;

    always #5 sys_clk = ~sys_clk;
    always #62.5 sample_clk = ~sample_clk;

    cvc_core_voltage i_cvc_core_voltage (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .boot_op_bits(4'hA),
        .boot_sr_code(7'h21),
        .scaling_port_select(scaling_port_select),
        .ctl_acc(ctl_acc),
        .ctl_ans(ctl_ans),
        .sr_acc(sr_acc),
        .sr_ans(sr_ans),
        .sample_clk(sample_clk),
        .drive_q(drive_q)
    );

    cvc_host_model i_cvc_host_model (
        .sys_clk(sys_clk),
        .scaling_port_select(scaling_port_select),
        .ctl_acc(ctl_acc),
        .ctl_ans(ctl_ans),
        .sr_acc(sr_acc),
        .sr_ans(sr_ans)
    );

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Case equality, so an unknown never passes.
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic acc(input logic sr, input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        i_cvc_host_model.xfer(sr, wr, a, d, rd_q, ack_q);
        chk("ack", 16'h0001, {15'h0000, ack_q});
    endtask

    task automatic rdc(input logic sr, input logic [7:0] a,
                       input logic [7:0] e);
        acc(sr, 1'b0, a, 8'h00);
        chk("rdata", {8'h00, e}, {8'h00, rd_q});
    endtask

    task automatic wt(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // Expected drive worked out from code and gain field.
    task automatic vchk(input int c, input logic [1:0] g);
        int gf;
        int v;
        gf = (g < 2'h2) ? 1 : int'(g);
        v = (c == 0) ? 0 : (c <= 3) ? 6000 : (c >= 75) ? 15000 : c*125+5625;
        v = v * gf;
        if (v > 33000)
            v = 33000;
        chk("code", 16'(c), {9'h000, drive_q.code});
        chk("gain", 16'(gf), {14'h0000, drive_q.gain_factor});
        chk("vout", 16'(v), drive_q.vout);
    endtask

    // Every ramp move must be exactly one code upward.
    always @(posedge sys_clk)
    begin
        code_prev <= drive_q.code;
        if (ramp_on && drive_q.code !== code_prev)
            chk("step", {9'h000, 7'(code_prev + 7'h01)},
                {9'h000, drive_q.code});
    end

    // Watchdog, well above the expected run of about 56 us.
    initial
    begin
        #300000;
        mismatches++;
        end_sim();
    end

    initial
    begin
        repeat (4) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        wt(2);
        rdc(1'b0, 8'h24, 8'h04);
        rdc(1'b0, 8'h22, 8'h50);
        rdc(1'b0, 8'h23, 8'h21);
        rdc(1'b0, 8'h30, 8'h00);
        acc(1'b1, 1'b1, 8'h23, 8'h11);
        acc(1'b1, 1'b1, 8'h22, 8'h7F);
        rdc(1'b0, 8'h22, 8'h50);
        rdc(1'b1, 8'h23, 8'h00);
        rdc(1'b0, 8'h23, 8'h21);
        i_cvc_host_model.set_sel(1'b1);
        acc(1'b1, 1'b1, 8'h23, 8'hB0);
        rdc(1'b1, 8'h23, 8'h30);
        rdc(1'b0, 8'h22, 8'h00);
        rdc(1'b1, 8'h24, 8'h00);
        acc(1'b0, 1'b1, 8'h24, 8'h01);
        acc(1'b1, 1'b1, 8'h22, 8'h90);
        wt(4);
        vchk(48, 2'h0);
        acc(1'b1, 1'b1, 8'h22, 8'h10);
        wt(4);
        vchk(16, 2'h0);
        // Voltage table under every gain setting, stepping bypassed.
        for (int g = 0; g < 4; g++)
        begin
            acc(1'b0, 1'b1, 8'h24, {g[1:0], 6'h01});
            foreach (codes[i])
            begin
                acc(1'b1, 1'b1, 8'h22, {1'b0, codes[i]});
                wt(4);
                vchk(int'(codes[i]), g[1:0]);
            end
        end
        // Supply states and current limit.
        for (int s = 0; s < 4; s++)
        begin
            acc(1'b0, 1'b1, 8'h24, {2'h0, s[0], 3'h0, s[1:0]});
            wt(3);
            chk("on", {15'h0000, s[0]}, {15'h0000, drive_q.on});
            chk("low", 16'(s == 3), {15'h0000, drive_q.low_power});
            chk("ilim", {15'h0000, s[0]},
                {15'h0000, drive_q.ilim_high});
        end
        // Ramp rates over 60 sampling edges.
        for (int t = 1; t < 8; t++)
        begin
            acc(1'b0, 1'b1, 8'h24, 8'h01);
            acc(1'b1, 1'b1, 8'h22, 8'h03);
            wt(4);
            acc(1'b0, 1'b1, 8'h24, {3'h0, t[2:0], 2'h1});
            acc(1'b1, 1'b1, 8'h22, 8'h4B);
            ramp_on = 1'b1;
            start = int'(drive_q.code);
            repeat (60) @(posedge sample_clk);
            wt(1);
            n = int'(drive_q.code) - start;
            chk("rate", 16'h0001,
                16'(n >= rate_steps[t-1] - 1 &&
                n <= rate_steps[t-1] + 1));
            vchk(int'(drive_q.code), 2'h0);
            ramp_on = 1'b0;
        end
        // A second turn-off reset in mid-run restores the defaults.
        acc(1'b0, 1'b1, 8'h24, 8'hC3);
        reset_n = 1'b0;
        wt(2);
        reset_n = 1'b1;
        wt(2);
        rdc(1'b0, 8'h24, 8'h04);
        rdc(1'b1, 8'h22, 8'h50);
        end_sim();
    end
endmodule
